// file: ram_pkg.sv
/*
 * Shared constants, types and decode helpers for the dual-port block RAM.
 * Assumes every user of it runs on pclk and imports it whole.
 */
package ram_pkg;

	////////////////////////////////////////////////////////////////////////
	// array geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 9;
	localparam int WORD_AW = 9;
	localparam int DEPTH = 512;
	localparam int OFF_W = 4;
	localparam int NUM_PORTS = 2;
	localparam int COUNT_W = 16;

	////////////////////////////////////////////////////////////////////////
	// register map (byte addresses) and reset values
	localparam int APB_AW = 12;
	localparam logic [11:0] REG_CTRL_OFF = 12'h000;
	localparam logic [11:0] REG_COUNT_OFF = 12'h004;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
	localparam int CTRL_EN_A_BIT = 0;
	localparam int CTRL_EN_B_BIT = 1;
	localparam int COUNT_A_LSB = 0;
	localparam int COUNT_B_LSB = 16;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;
	localparam logic [8:0] WORD_RESET = 9'h000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// aspect ratio codes
	typedef enum logic [1:0] {
		ASPECT_4KX1 = 2'b00,
		ASPECT_2KX2 = 2'b01,
		ASPECT_1KX4 = 2'b10,
		ASPECT_512X9 = 2'b11
	} aspect_t;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic clock;
		logic select_n;
		logic write_select_n;
		logic stage_select;
		logic write_behavior;
		logic [1:0] aspect;
		logic [ADDR_W-1:0] location;
		logic [DATA_W-1:0] wdata;
	} port_in_t;

	localparam int PORT_IN_W = $bits(port_in_t);

	typedef struct packed {
		logic [WORD_AW-1:0] word;
		logic [OFF_W-1:0] off;
		logic [DATA_W-1:0] mask;
	} lane_t;

	////////////////////////////////////////////////////////////////////////
	// location to word, bit offset and lane mask
	function automatic lane_t decode_lane(input logic [1:0] aspect,
		input logic [ADDR_W-1:0] loc);
		lane_t l;
		l = '0;
		case (aspect)
			ASPECT_4KX1:
			begin
				l.word = loc[11:3];
				l.off = {1'b0, loc[2:0]};
				l.mask = 9'h001;
			end
			ASPECT_2KX2:
			begin
				l.word = loc[10:2];
				l.off = {1'b0, loc[1:0], 1'b0};
				l.mask = 9'h003;
			end
			ASPECT_1KX4:
			begin
				l.word = loc[9:1];
				l.off = {1'b0, loc[0], 2'b00};
				l.mask = 9'h00F;
			end
			default:
			begin
				l.word = loc[8:0];
				l.off = 4'h0;
				l.mask = 9'h1FF;
			end
		endcase
		return l;
	endfunction

endpackage

// file: ram_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin-level inputs.
 * Assumes the bundle is quasi-static around the sampling point.
 */
`timescale 1ns/1ps
module ram_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bundle
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// file: ram_apb_regs.sv
/*
 * APB slave holding the port enable register and the access counter view.
 * Assumes an APB master on pclk; one wait-free access phase per transfer.
 */
`timescale 1ns/1ps
module ram_apb_regs (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ram_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// block side
	input wire logic [31:0] count_view,
	output logic [1:0] port_enable,
	output logic count_clear
);
	import ram_pkg::*;

	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d;
	logic err_q, err_d;
	logic clr_q, clr_d;
	logic hit_ctrl, hit_count, commit;

	always_comb
	begin
		hit_ctrl = (paddr == REG_CTRL_OFF);
		hit_count = (paddr == REG_COUNT_OFF);
		commit = psel & penable & ready_q;
		ready_d = psel & ~penable & ~ready_q;
		rdata_d = rdata_q;
		err_d = 1'b0;
		if (ready_d)
		begin
			rdata_d = DATA_RESET;
			if (!pwrite && hit_ctrl)
				rdata_d = ctrl_q;
			else if (!pwrite && hit_count)
				rdata_d = count_view;
			err_d = ~(hit_ctrl | hit_count);
		end
		ctrl_d = ctrl_q;
		if (commit && pwrite && hit_ctrl)
			ctrl_d = {30'h0, pwdata[CTRL_EN_B_BIT], pwdata[CTRL_EN_A_BIT]};
		clr_d = commit & pwrite & hit_count;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= CTRL_RESET;
			rdata_q <= DATA_RESET;
			ready_q <= 1'b0;
			err_q <= 1'b0;
			clr_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
			clr_q <= clr_d;
		end
	end

	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;
	assign port_enable = {ctrl_q[CTRL_EN_B_BIT], ctrl_q[CTRL_EN_A_BIT]};
	assign count_clear = clr_q;
endmodule

// file: dual_port_block_ram.sv
/*
 * Dual-port 4k-bit (4608 with the ninth lane) block RAM with two pin ports.
 * Assumes port pins come from fabric logic outside pclk: each port clock is
 * sampled through two flops and its rising edge becomes one pclk strobe, so
 * pclk must run well above twice either port clock. Register access via APB.
 */
`timescale 1ns/1ps
module dual_port_block_ram (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ram_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port a
	input wire logic port_a_clock,
	input wire logic port_a_select_n,
	input wire logic port_a_write_select_n,
	input wire logic port_a_output_stage_select,
	input wire logic port_a_write_output_behavior,
	input wire logic [1:0] port_a_aspect_select,
	input wire logic [ram_pkg::ADDR_W-1:0] port_a_location,
	input wire logic [ram_pkg::DATA_W-1:0] port_a_write_data,
	output logic [ram_pkg::DATA_W-1:0] port_a_read_data,
	// port b
	input wire logic port_b_clock,
	input wire logic port_b_select_n,
	input wire logic port_b_write_select_n,
	input wire logic port_b_output_stage_select,
	input wire logic port_b_write_output_behavior,
	input wire logic [1:0] port_b_aspect_select,
	input wire logic [ram_pkg::ADDR_W-1:0] port_b_location,
	input wire logic [ram_pkg::DATA_W-1:0] port_b_write_data,
	output logic [ram_pkg::DATA_W-1:0] port_b_read_data
);
	import ram_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// storage and per-port wiring
	logic [DATA_W-1:0] mem [DEPTH];
	port_in_t raw [NUM_PORTS];
	port_in_t syn [NUM_PORTS];
	logic [NUM_PORTS-1:0] port_enable;
	logic [NUM_PORTS-1:0] wr_en;
	logic [WORD_AW-1:0] wr_word [NUM_PORTS];
	lane_t wr_lane [NUM_PORTS];
	logic [DATA_W-1:0] wr_data [NUM_PORTS];
	logic [DATA_W-1:0] word_next [NUM_PORTS];
	logic [DATA_W-1:0] dout_q [NUM_PORTS];
	logic [COUNT_W-1:0] count_q [NUM_PORTS];
	logic [31:0] count_view;
	logic count_clear;

	////////////////////////////////////////////////////////////////////////
	// pin bundles
	always_comb
	begin
		raw[0].clock = port_a_clock;
		raw[0].select_n = port_a_select_n;
		raw[0].write_select_n = port_a_write_select_n;
		raw[0].stage_select = port_a_output_stage_select;
		raw[0].write_behavior = port_a_write_output_behavior;
		raw[0].aspect = port_a_aspect_select;
		raw[0].location = port_a_location;
		raw[0].wdata = port_a_write_data;
		raw[1].clock = port_b_clock;
		raw[1].select_n = port_b_select_n;
		raw[1].write_select_n = port_b_write_select_n;
		raw[1].stage_select = port_b_output_stage_select;
		raw[1].write_behavior = port_b_write_output_behavior;
		raw[1].aspect = port_b_aspect_select;
		raw[1].location = port_b_location;
		raw[1].wdata = port_b_write_data;
	end

	////////////////////////////////////////////////////////////////////////
	// register slave
	ram_apb_regs u_regs (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.count_view(count_view),
		.port_enable(port_enable),
		.count_clear(count_clear)
	);

	assign count_view = {count_q[1], count_q[0]};

	////////////////////////////////////////////////////////////////////////
	// lane helpers
	function automatic logic [DATA_W-1:0] pick_lane(input logic [DATA_W-1:0] word,
		input lane_t ln);
		return (word >> ln.off) & ln.mask;
	endfunction

	// replace the lane's bits in a word, leaving the other lanes alone
	function automatic logic [DATA_W-1:0] merge_lane(input logic [DATA_W-1:0] word,
		input lane_t ln, input logic [DATA_W-1:0] bits);
		logic [DATA_W-1:0] keep;
		keep = word & ~(ln.mask << ln.off);
		return keep | ((bits & ln.mask) << ln.off);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// one slice per port
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : g_port
			// per-port state and next values
			port_in_t s;
			lane_t lane;
			logic clk_prev_q, clk_prev_d;
			logic strobe, active, is_read, is_write;
			logic [DATA_W-1:0] rd_val, result;
			logic [DATA_W-1:0] last_read_q, last_read_d;
			logic [DATA_W-1:0] stage_q, stage_d;
			logic [DATA_W-1:0] out_q, out_d;
			logic [COUNT_W-1:0] cnt_q, cnt_d;

			// pins pass two flops before any logic reads them
			ram_sync #(
				.W(PORT_IN_W)
			) u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.d(raw[p]),
				.q(syn[p])
			);

			////////////////////////////////////////////////////////////////
			// access decode on the synced port clock's rising edge
			always_comb
			begin
				s = syn[p];
				lane = decode_lane(s.aspect, s.location);
				clk_prev_d = s.clock;
				strobe = s.clock & ~clk_prev_q;
				active = strobe & ~s.select_n & port_enable[p];
				is_write = active & ~s.write_select_n;
				is_read = active & s.write_select_n;
			end

			// reset low matches the idle pin, so no false edge follows reset
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					clk_prev_q <= 1'b0;
				end
				else
				begin
					clk_prev_q <= clk_prev_d;
				end
			end

			////////////////////////////////////////////////////////////////
			// read path and last read hold
			always_comb
			begin
				rd_val = pick_lane(mem[lane.word], lane);
				last_read_d = last_read_q;
				if (is_read)
				begin
					last_read_d = rd_val;
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					last_read_q <= WORD_RESET;
				end
				else
				begin
					last_read_q <= last_read_d;
				end
			end

			////////////////////////////////////////////////////////////////
			// output stage; the pipeline register only moves on enabled accesses
			always_comb
			begin
				if (is_read)
					result = rd_val;
				else if (s.write_behavior)
					result = s.wdata & lane.mask;
				else
					result = last_read_q;
				stage_d = stage_q;
				out_d = out_q;
				if (active)
				begin
					stage_d = result;
					out_d = s.stage_select ? stage_q : result;
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					stage_q <= WORD_RESET;
					out_q <= WORD_RESET;
				end
				else
				begin
					stage_q <= stage_d;
					out_q <= out_d;
				end
			end

			////////////////////////////////////////////////////////////////
			// access counter; an access in the clear cycle still counts
			always_comb
			begin
				if (count_clear)
				begin
					cnt_d = COUNT_W'(active);
				end
				else
				begin
					cnt_d = cnt_q + COUNT_W'(active);
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cnt_q <= COUNT_RESET;
				end
				else
				begin
					cnt_q <= cnt_d;
				end
			end

			assign wr_en[p] = is_write & presetn;
			assign wr_word[p] = lane.word;
			assign wr_lane[p] = lane;
			assign wr_data[p] = s.wdata;
			assign dout_q[p] = out_q;
			assign count_q[p] = cnt_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// same-word writes from both ports keep both lanes; port b wins overlaps
	always_comb
	begin
		word_next[0] = merge_lane(mem[wr_word[0]], wr_lane[0], wr_data[0]);
		if (wr_en[0] && wr_en[1] && (wr_word[0] == wr_word[1]))
		begin
			word_next[1] = merge_lane(word_next[0], wr_lane[1], wr_data[1]);
		end
		else
		begin
			word_next[1] = merge_lane(mem[wr_word[1]], wr_lane[1], wr_data[1]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// array writes; no reset so contents survive it
	always_ff @(posedge pclk)
	begin
		for (int i = 0; i < NUM_PORTS; i++)
		begin
			if (wr_en[i])
				mem[wr_word[i]] <= word_next[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign port_a_read_data = dout_q[0];
	assign port_b_read_data = dout_q[1];

endmodule

// file: dpram_checker.sv
/* Port-level assertions for the dual-port RAM.
   Assumes bind by name; pass-through writes use 512x9. */
`timescale 1ns/1ps
module dpram_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// port a
	input wire logic port_a_clock,
	input wire logic port_a_select_n,
	input wire logic port_a_write_select_n,
	input wire logic port_a_output_stage_select,
	input wire logic port_a_write_output_behavior,
	input wire logic [ram_pkg::DATA_W-1:0] port_a_write_data,
	input wire logic [ram_pkg::DATA_W-1:0] port_a_read_data,
	// port b
	input wire logic [ram_pkg::DATA_W-1:0] port_b_read_data
);
	import ram_pkg::*;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////
	sequence a_edge;
		$rose(port_a_clock) && !port_a_select_n;
	endsequence
	sequence a_write;
		a_edge ##0 (!port_a_write_select_n && !port_a_output_stage_select);
	endsequence
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	ready_idle_a: assert property (!psel |=> !pready)
		else $error("ready without request");
	err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error response");
	reset_clear_a: assert property ($rose(presetn) |-> prdata == 32'h0
		&& port_a_read_data == 9'h000 && port_b_read_data == 9'h000)
		else $error("output not cleared");
	write_pass_a: assert property (a_write ##0 port_a_write_output_behavior
		|-> ##[2:6] port_a_read_data == port_a_write_data)
		else $error("write data not passed");
	write_hold_a: assert property (a_write ##0 !port_a_write_output_behavior
		|=> $stable(port_a_read_data)[*6])
		else $error("output moved on write");
	idle_hold_a: assert property ($rose(port_a_clock) && port_a_select_n
		|=> $stable(port_a_read_data)[*6])
		else $error("output moved while off");
endmodule

// file: fabric_model.sv
/* Fabric logic driving both RAM pin ports.
   Assumes pclk runs well above the port clocks made here. */
`timescale 1ns/1ps
module fabric_model (
	// clock
	input wire logic pclk,
	// port pins
	output ram_pkg::port_in_t port_a,
	output ram_pkg::port_in_t port_b
);
	import ram_pkg::*;
	localparam port_in_t IDLE = '{select_n: 1'b1, write_select_n: 1'b1, default: '0};
	initial
	begin
		port_a = IDLE;
		port_b = IDLE;
	end
	task automatic drive(input bit p, input port_in_t v);
		if (p)
			port_b <= v;
		else
			port_a <= v;
	endtask
	// pins settle, clock high then low, then data lines toggle
	task automatic access(input bit p, input port_in_t v, input int slow);
		port_in_t w;
		w = v;
		w.clock = 1'b0;
		w.location = v.location & (12'hFFF >> v.aspect);
		drive(p, w);
		repeat (2 + slow) @(posedge pclk);
		w.clock = 1'b1;
		drive(p, w);
		repeat (4 + slow) @(posedge pclk);
		w.clock = 1'b0;
		drive(p, w);
		repeat (4) @(posedge pclk);
		w.wdata = ~w.wdata;
		drive(p, w);
		@(posedge pclk);
	endtask
endmodule

// file: tb.sv
/* Testbench for the dual-port RAM: APB registers and both ports.
   Assumes the fabric model drives the port pins. */
`timescale 1ns/1ps
module tb;
	import ram_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] q;
	logic e;
	port_in_t pa;
	port_in_t pb;
	logic [DATA_W-1:0] rd_a;
	logic [DATA_W-1:0] rd_b;
	int num_errors = 0;
	int compares = 0;
	always #25 pclk = ~pclk;
	fabric_model fab_u (.pclk, .port_a(pa), .port_b(pb));
	dual_port_block_ram dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .port_a_clock(pa.clock), .port_a_select_n(pa.select_n),
		.port_a_write_select_n(pa.write_select_n), .port_a_output_stage_select(pa.stage_select),
		.port_a_write_output_behavior(pa.write_behavior), .port_a_aspect_select(pa.aspect),
		.port_a_location(pa.location), .port_a_write_data(pa.wdata), .port_a_read_data(rd_a),
		.port_b_clock(pb.clock), .port_b_select_n(pb.select_n),
		.port_b_write_select_n(pb.write_select_n), .port_b_output_stage_select(pb.stage_select),
		.port_b_write_output_behavior(pb.write_behavior), .port_b_aspect_select(pb.aspect),
		.port_b_location(pb.location), .port_b_write_data(pb.wdata), .port_b_read_data(rd_b));
	////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// c = select_n, write_select_n, stage select, write behaviour
	task automatic acc(input bit p, input logic [3:0] c, input logic [1:0] s,
		input logic [11:0] l, input logic [8:0] d, input int w);
		fab_u.access(p, {1'b0, c, s, l, d}, w);
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////
	task automatic t_regs();
		apb(1'b0, REG_CTRL_OFF, '0);
		chk("ctrl", q, CTRL_RESET);
		apb(1'b1, 12'h008, 32'hFFFF_FFFF);
		chk("unmapped err", e, 1'b1);
		chk("unmapped data", q, '0);
	endtask
	task automatic t_shapes();
		logic [1:0] s [4] = '{2'b10, 2'b10, 2'b01, 2'b00};
		logic [11:0] l [4] = '{12'h3FE, 12'h3FF, 12'h7FF, 12'hFFF};
		logic [8:0] x [4] = '{9'h006, 9'h00B, 9'h002, 9'h001};
		acc(0, 4'b0001, 2'b11, 12'h1FF, 9'h0B6, 0);
		chk("pass", rd_a, 9'h0B6);
		for (int i = 0; i < 4; i++)
		begin
			acc(0, 4'b0101, s[i], l[i], 9'h1FF, 0);
			chk("narrow read", rd_a, x[i]);
		end
		acc(0, 4'b0000, 2'b00, 12'hFF9, 9'h000, 0);
		chk("write hold", rd_a, 9'h001);
		acc(0, 4'b0100, 2'b11, 12'h1FF, 9'h000, 0);
		chk("full read", rd_a, 9'h0B4);
	endtask
	task automatic t_pipe();
		acc(1, 4'b0001, 2'b11, 12'h000, 9'h055, 0);
		acc(1, 4'b0001, 2'b11, 12'h001, 9'h0AA, 0);
		chk("pass b", rd_b, 9'h0AA);
		acc(1, 4'b0110, 2'b11, 12'h000, 9'h000, 0);
		acc(1, 4'b0110, 2'b11, 12'h001, 9'h000, 1);
		chk("piped read", rd_b, 9'h055);
		acc(1, 4'b0100, 2'b11, 12'h001, 9'h000, 0);
		chk("direct read", rd_b, 9'h0AA);
	endtask
	task automatic t_hold();
		acc(0, 4'b1001, 2'b11, 12'h001, 9'h0FF, 0);
		chk("deselected", rd_a, 9'h0B4);
		apb(1'b1, REG_CTRL_OFF, 32'h2);
		acc(0, 4'b0100, 2'b11, 12'h000, 9'h000, 0);
		chk("port off", rd_a, 9'h0B4);
		apb(1'b1, REG_CTRL_OFF, CTRL_RESET);
		acc(0, 4'b0100, 2'b11, 12'h001, 9'h000, 0);
		chk("not written", rd_a, 9'h0AA);
	endtask
	task automatic t_conc();
		apb(1'b1, REG_COUNT_OFF, '0);
		fork
			acc(0, 4'b0000, 2'b11, 12'h002, 9'h111, 0);
			acc(1, 4'b0000, 2'b11, 12'h003, 9'h122, 2);
		join
		fork
			acc(0, 4'b0100, 2'b11, 12'h003, 9'h000, 1);
			acc(1, 4'b0100, 2'b11, 12'h002, 9'h000, 0);
		join
		chk("cross a", rd_a, 9'h122);
		chk("cross b", rd_b, 9'h111);
		apb(1'b0, REG_COUNT_OFF, '0);
		chk("count", q, 32'h0002_0002);
	endtask
	task automatic t_reset();
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("reset a", rd_a, '0);
		chk("reset b", rd_b, '0);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		acc(0, 4'b0100, 2'b11, 12'h003, 9'h000, 0);
		chk("kept", rd_a, 9'h122);
	endtask
	task automatic t_merge();
		fork
			acc(0, 4'b0000, 2'b10, 12'h006, 9'h005, 0);
			acc(1, 4'b0000, 2'b10, 12'h007, 9'h00A, 0);
		join
		acc(0, 4'b0100, 2'b11, 12'h003, 9'h000, 0);
		chk("same word", rd_a, 9'h1A5);
	endtask
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_regs();
		t_shapes();
		t_pipe();
		t_hold();
		t_conc();
		t_reset();
		t_merge();
		tally_and_finish();
	end
	initial
	begin
		repeat (5000) @(posedge pclk);
		num_errors++;
		tally_and_finish();
	end
endmodule
bind dual_port_block_ram dpram_checker chk_u (.*);
